// ==== logic/ppc_port_config.sv ====
/*
 Port configuration register bank of a copper transceiver, on AXI4-Lite.
 Assumes the core takes the decoded controls synchronously to aclk and
 that the configuration memory bit is stable when soft reset is issued.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_port_config (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic eeprom_speed_downgrade_default,
	input wire ppc_pkg::ppc_speed_t speed_mode,
	input wire logic line_link_up,
	output logic alt_next_page_en,
	output logic crossover_auto_select_strict,
	output logic preamble_pass,
	output logic speed_downgrade_en,
	output logic tp_loopback_disable,
	output logic jabber_detect_disable,
	output logic bypass_block_coder,
	output logic bypass_scrambler,
	output logic tx_disable,
	output logic link_indication,
	output logic link_monitor_good_state,
	output logic autoneg_bypass
);
	import ppc_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`PPC_CFG_W-1:0] cfg_q;
	logic soft_reset_q;
	logic rsvd_written_q;
	logic wr_fire, rd_fire, wr_err, rd_err;
	logic [11:0] wr_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [11:0] rd_addr;
	logic [`PPC_CFG_W-1:0] cfg_wr;
	logic cfg_hit, ctrl_hit;

	assign rd_addr = s_axi_araddr;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	ppc_axil_slave #(
		.AW(`PPC_ADDR_W)
	) u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_fire(rd_fire),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Byte lanes merge into the stored value; bit 15 has no storage
	always_comb
	begin
		cfg_hit = wr_addr == `PPC_ADDR_CFG;
		ctrl_hit = wr_addr == `PPC_ADDR_CTRL;
		wr_err = !(cfg_hit || ctrl_hit || wr_addr == `PPC_ADDR_STATUS);
		cfg_wr = cfg_q;
		if (wr_strb[0])
			cfg_wr[7:0] = wr_data[7:0]; // RL1
		if (wr_strb[1])
			cfg_wr[14:8] = wr_data[14:8]; // RL15
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Soft reset restores defaults except the downgrade bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cfg_q <= `PPC_CFG_RESET; // RL4 RL5 RL7
		else if (soft_reset_q)
		begin
			cfg_q <= `PPC_CFG_RESET; // RL4 RL7
			cfg_q[`PPC_BIT_DOWNGRADE] <= eeprom_speed_downgrade_default; // RL6
		end
		else if (wr_fire && cfg_hit)
			cfg_q <= cfg_wr; // RL16
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Soft reset is a one-cycle pulse, so it never sticks
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			soft_reset_q <= 1'b0;
		else
			soft_reset_q <= wr_fire && ctrl_hit && wr_strb[0] && wr_data[`PPC_CTRL_SOFT_RESET];
	end

	// Sticky note of nonzero writes to reserved bits; a new set beats a clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rsvd_written_q <= 1'b0;
		else if (wr_fire && cfg_hit && ((cfg_wr & `PPC_CFG_RSVD_MASK) != 15'h0000 ||
			(wr_strb[1] && wr_data[15]))) // RL1 RL15
			rsvd_written_q <= 1'b1;
		else if (wr_fire && ctrl_hit && wr_strb[0] && wr_data[`PPC_CTRL_CLR_RSVD])
			rsvd_written_q <= 1'b0;
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	// Unmapped reads return zero with a decode error
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (rd_addr)
			`PPC_ADDR_CFG:
				rd_data[`PPC_CFG_W-1:0] = cfg_q; // RL15
			`PPC_ADDR_CTRL:
				rd_data = 32'h0000_0000;
			`PPC_ADDR_STATUS:
			begin
				rd_data[`PPC_ST_LINK] = link_indication;
				rd_data[`PPC_ST_MONITOR_GOOD] = link_monitor_good_state;
				rd_data[`PPC_ST_AN_BYPASS] = autoneg_bypass;
				rd_data[`PPC_ST_RSVD_WRITTEN] = rsvd_written_q;
				rd_data[`PPC_ST_SPEED_LSB +: 2] = speed_mode;
			end
			default:
				rd_err = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Controls to the transceiver core
	// ----------------------------------------
	// Each control is a stored bit, so outputs come straight from flops
	assign alt_next_page_en = cfg_q[`PPC_BIT_ALT_NP]; // RL2
	assign crossover_auto_select_strict = cfg_q[`PPC_BIT_MDIX_STRICT]; // RL3
	assign preamble_pass = cfg_q[`PPC_BIT_PREAMBLE]; // RL4
	assign speed_downgrade_en = cfg_q[`PPC_BIT_DOWNGRADE]; // RL5
	assign tp_loopback_disable = cfg_q[`PPC_BIT_TP_LB_DIS]; // RL7
	assign jabber_detect_disable = cfg_q[`PPC_BIT_JABBER_DIS]; // RL8
	assign bypass_block_coder = cfg_q[`PPC_BIT_BYP_4B5B]; // RL9
	assign bypass_scrambler = cfg_q[`PPC_BIT_BYP_SCR]; // RL10
	assign tx_disable = cfg_q[`PPC_BIT_TX_DIS]; // RL11

	// ----------------------------------------
	// Forced link, by speed
	// ----------------------------------------
	ppc_link_mode u_link (
		.aclk(aclk),
		.aresetn(aresetn),
		.speed_mode(speed_mode),
		.force_link(cfg_q[`PPC_BIT_FORCE_LINK]),
		.line_link_up(line_link_up),
		.link_indication_q(link_indication),
		.link_monitor_good_state_q(link_monitor_good_state),
		.autoneg_bypass_q(autoneg_bypass)
	);
endmodule // ppc_port_config
`default_nettype wire

// ==== inc/ppc_defines.svh ====
/*
 Offsets, field positions and reset values of the port configuration bank.
 Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
// Behaviour
// RL1 - Software writes zero to reserved bits 0,3:2,6,9
// RL2 - Bit 1 enables alternate next-page behaviour
// RL3 - Bit 4 one: strict crossover; zero: longer swap timer
// RL4 - Bit 5 passes preamble on receive; resets one
// RL5 - Bit 7 enables speed downgrade; hardware reset zero
// RL6 - Soft reset loads downgrade bit from configuration memory
// RL7 - Bit 8 stops 10BASE-T half-duplex loopback; resets one
// RL8 - Bit 10 disables 10BASE-T jabber detection
// RL9 - Bit 11 bypasses 100BASE-TX block coder
// RL10 - Bit 12 bypasses 100BASE-TX scrambler
// RL11 - Bit 13 turns the transmitter off
// RL12 - Bit 14 forces link indication in 10BASE-T
// RL13 - Bit 14 forces link monitor good in 100BASE-T
// RL14 - Bit 14 only bypasses negotiation at gigabit
// RL15 - Bits 16:15 read zero, written zero
// RL16 - Writes take effect when the write completes
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PPC_ADDR_W 12
`define PPC_CFG_INDEX 12'h010
`define PPC_ADDR_CTRL 12'h000
`define PPC_ADDR_STATUS 12'h004
`define PPC_ADDR_CFG 12'h040

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define PPC_CFG_W 15
`define PPC_BIT_ALT_NP 1
`define PPC_BIT_MDIX_STRICT 4
`define PPC_BIT_PREAMBLE 5
`define PPC_BIT_DOWNGRADE 7
`define PPC_BIT_TP_LB_DIS 8
`define PPC_BIT_JABBER_DIS 10
`define PPC_BIT_BYP_4B5B 11
`define PPC_BIT_BYP_SCR 12
`define PPC_BIT_TX_DIS 13
`define PPC_BIT_FORCE_LINK 14
`define PPC_CFG_RESET 15'h0120
`define PPC_CFG_RSVD_MASK 15'h024D

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define PPC_CTRL_SOFT_RESET 0
`define PPC_CTRL_CLR_RSVD 1
`define PPC_ST_LINK 0
`define PPC_ST_MONITOR_GOOD 1
`define PPC_ST_AN_BYPASS 2
`define PPC_ST_RSVD_WRITTEN 3
`define PPC_ST_SPEED_LSB 4

`endif

// ==== inc/ppc_pkg.sv ====
/*
 Types shared by the port configuration bank.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package ppc_pkg;
	// Operating speed reported by the transceiver core
	typedef enum logic [1:0] {
		PPC_SPEED_10 = 2'h0,
		PPC_SPEED_100 = 2'h1,
		PPC_SPEED_1000 = 2'h2,
		PPC_SPEED_RSVD = 2'h3
	} ppc_speed_t;

	// AXI response codes used by the slave
	typedef enum logic [1:0] {
		PPC_RESP_OKAY = 2'h0,
		PPC_RESP_DECERR = 2'h3
	} ppc_resp_t;
endpackage
`default_nettype wire

// ==== logic/ppc_axil_slave.sv ====
/*
 AXI4-Lite slave handshake: one write and one read under way at a time.
 Assumes the parent decodes addresses combinationally from wr/rd strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_axil_slave #(
	parameter int AW = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_fire,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_fire,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	import ppc_pkg::*;

	logic aw_full_q, w_full_q, aw_full_d, w_full_d, bvalid_d, rvalid_d;
	logic [AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// ----------------------------------------
	// Next-state of both channels
	// ----------------------------------------
	always_comb
	begin
		wr_fire = aw_full_q & w_full_q & ~bvalid;
		rd_fire = arvalid & arready;
		aw_full_d = (aw_full_q | (awvalid & awready)) & ~wr_fire;
		w_full_d = (w_full_q | (wvalid & wready)) & ~wr_fire;
		bvalid_d = wr_fire | (bvalid & ~bready);
		rvalid_d = rd_fire | (rvalid & ~rready);
	end

	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;

	// Address and data are held independently, so either may come first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= PPC_RESP_OKAY;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready <= ~aw_full_d & ~bvalid_d;
			wready <= ~w_full_d & ~bvalid_d;
			bvalid <= bvalid_d;
			if (wr_fire)
				bresp <= wr_err ? PPC_RESP_DECERR : PPC_RESP_OKAY;
		end
	end

	// Payload latches; no reset needed for data
	always_ff @(posedge aclk)
	begin
		if (awvalid && awready)
			awaddr_q <= awaddr;
		if (wvalid && wready)
		begin
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= PPC_RESP_OKAY;
		end
		else
		begin
			arready <= ~rvalid_d;
			rvalid <= rvalid_d;
			if (rd_fire)
			begin
				rdata <= rd_data;
				rresp <= rd_err ? PPC_RESP_DECERR : PPC_RESP_OKAY;
			end
		end
	end
endmodule // ppc_axil_slave
`default_nettype wire

// ==== logic/ppc_link_mode.sv ====
/*
 Speed-dependent meaning of the forced-link control.
 Assumes speed and line link status are synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_link_mode (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ppc_pkg::ppc_speed_t speed_mode,
	input wire logic force_link,
	input wire logic line_link_up,
	output logic link_indication_q,
	output logic link_monitor_good_state_q,
	output logic autoneg_bypass_q
);
	import ppc_pkg::*;

	// Gigabit keeps the true status; slower modes see the force
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link_indication_q <= 1'b0;
			link_monitor_good_state_q <= 1'b0;
			autoneg_bypass_q <= 1'b0;
		end
		else
		begin
			unique case (speed_mode)
				PPC_SPEED_10:
					link_indication_q <= line_link_up | force_link; // RL12
				PPC_SPEED_100:
					link_indication_q <= line_link_up | force_link; // RL13
				default:
					link_indication_q <= line_link_up; // RL14
			endcase
			link_monitor_good_state_q <= force_link && speed_mode == PPC_SPEED_100; // RL13
			autoneg_bypass_q <= force_link && speed_mode == PPC_SPEED_1000; // RL14
		end
	end
endmodule // ppc_link_mode
`default_nettype wire

// ==== tb/ppc_port_config_properties.sv ====
/*
 Assertions on the ports of the port configuration bank.
 Assumes the bind below attaches it to ppc_port_config.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_port_config_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire ppc_pkg::ppc_speed_t speed_mode,
	input wire logic line_link_up,
	input wire logic alt_next_page_en,
	input wire logic crossover_auto_select_strict,
	input wire logic preamble_pass,
	input wire logic speed_downgrade_en,
	input wire logic tp_loopback_disable,
	input wire logic jabber_detect_disable,
	input wire logic bypass_block_coder,
	input wire logic bypass_scrambler,
	input wire logic tx_disable,
	input wire logic link_indication,
	input wire logic link_monitor_good_state,
	input wire logic autoneg_bypass
);
	import ppc_pkg::*;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	logic [8:0] cfg_v;
	// Controls gathered in register bit order
	assign cfg_v = {tx_disable, bypass_scrambler, bypass_block_coder, jabber_detect_disable,
		tp_loopback_disable, speed_downgrade_en, preamble_pass, crossover_auto_select_strict, alt_next_page_en};
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	cfg_reset_a: assert property ($rose(aresetn) |-> cfg_v == 9'h014)
		else $error("controls off their reset values");
	cfg_by_write_a: assert property (!$stable(cfg_v) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("controls moved without a write");
	mon_good_speed_a: assert property (link_monitor_good_state |-> $past(speed_mode) == PPC_SPEED_100)
		else $error("monitor good outside 100M");
	an_bypass_speed_a: assert property (autoneg_bypass |-> $past(speed_mode) == PPC_SPEED_1000)
		else $error("negotiation bypass outside gigabit");
	gig_true_link_a: assert property ($past(aresetn) && $past(speed_mode) == PPC_SPEED_1000
		|-> link_indication == $past(line_link_up))
		else $error("gigabit link indication not true status");
	link_follows_a: assert property ($past(aresetn) && $past(line_link_up) |-> link_indication)
		else $error("link up not indicated");
	forced_link_pair_a: assert property (link_monitor_good_state |-> link_indication)
		else $error("monitor good without link indication");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
		else $error("upper read bits not zero");
	// Main scenarios reached
	cover property (link_monitor_good_state);
	cover property (autoneg_bypass);
	cover property ($rose(speed_downgrade_en));
endmodule // ppc_port_config_properties
bind ppc_port_config ppc_port_config_properties ppc_port_config_properties_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rdata(s_axi_rdata), .speed_mode(speed_mode), .line_link_up(line_link_up),
	.alt_next_page_en(alt_next_page_en), .crossover_auto_select_strict(crossover_auto_select_strict),
	.preamble_pass(preamble_pass), .speed_downgrade_en(speed_downgrade_en),
	.tp_loopback_disable(tp_loopback_disable), .jabber_detect_disable(jabber_detect_disable),
	.bypass_block_coder(bypass_block_coder), .bypass_scrambler(bypass_scrambler), .tx_disable(tx_disable),
	.link_indication(link_indication), .link_monitor_good_state(link_monitor_good_state),
	.autoneg_bypass(autoneg_bypass)
);
`default_nettype wire

// ==== tb/ppc_mgmt_master.sv ====
/*
 Management controller model: AXI4-Lite master with write and read tasks.
 Assumes one clock shared with the slave; waits are cut by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_mgmt_master (
	input wire logic aclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Idle bus at time zero
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// Released address and data are inverted so a stale value is never mistaken for data
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
			begin
				awvalid <= 1'h0;
				awaddr <= ~a;
			end
			if (wvalid && wready)
			begin
				wvalid <= 1'h0;
				wdata <= ~d;
			end
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask
	// Read: address held until taken, rready held until data seen
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		araddr <= ~a;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
endmodule // ppc_mgmt_master
`default_nettype wire

// ==== tb/phy_port_config_register_bench.sv ====
/*
 Self-checking bench of the port configuration bank.
 Assumes the design, package, defines and the master model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ppc_defines.svh"
module phy_port_config_register_bench;
	import ppc_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic eeprom = 1'h0;
	logic line_up = 1'h0;
	ppc_speed_t spd = PPC_SPEED_10;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	wire [8:0] cfg_o;
	logic li, lm, ab;
	int error_cnt = 0;
	int check_count = 0;
	// 10 MHz clock
	always #50 aclk = ~aclk;
	ppc_port_config ppc_port_config_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.eeprom_speed_downgrade_default(eeprom), .speed_mode(spd), .line_link_up(line_up),
		.alt_next_page_en(cfg_o[0]), .crossover_auto_select_strict(cfg_o[1]), .preamble_pass(cfg_o[2]),
		.speed_downgrade_en(cfg_o[3]), .tp_loopback_disable(cfg_o[4]), .jabber_detect_disable(cfg_o[5]),
		.bypass_block_coder(cfg_o[6]), .bypass_scrambler(cfg_o[7]), .tx_disable(cfg_o[8]),
		.link_indication(li), .link_monitor_good_state(lm), .autoneg_bypass(ab));
	ppc_mgmt_master ppc_mgmt_master_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		ppc_mgmt_master_inst.wr(a, d, s, r);
		chk(r, er);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		ppc_mgmt_master_inst.rd(a, d, r);
		chk(d, e);
		chk(r, er);
	endtask
	task automatic give_verdict;
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdc(`PPC_ADDR_CFG, 32'h120, 2'h0);
		chk(cfg_o, 9'h014);
	endtask
	// Each control alone, so a swapped bit shows
	task automatic t_fields;
		int pos[9] = '{1, 4, 5, 7, 8, 10, 11, 12, 13};
		for (int i = 0; i < 9; i++)
		begin
			wrc(`PPC_ADDR_CFG, 32'h1 << pos[i], 4'hF, 2'h0);
			rdc(`PPC_ADDR_CFG, 32'h1 << pos[i], 2'h0);
			chk(cfg_o, 9'h1 << i);
		end
	endtask
	// Lane 0 only, then all ones: top bits never stored
	task automatic t_rsvd;
		wrc(`PPC_ADDR_CFG, 32'hFFFFFFFF, 4'h1, 2'h0);
		rdc(`PPC_ADDR_CFG, 32'h20FF, 2'h0);
		wrc(`PPC_ADDR_CFG, 32'hFFFFFFFF, 4'hF, 2'h0);
		rdc(`PPC_ADDR_CFG, 32'h7FFF, 2'h0);
		chk(cfg_o, 9'h1FF);
		rdc(`PPC_ADDR_STATUS, 32'h9, 2'h0);
		wrc(`PPC_ADDR_CTRL, 32'h2, 4'h1, 2'h0);
		rdc(`PPC_ADDR_STATUS, 32'h1, 2'h0);
	endtask
	// Reserved speed code keeps the true status, like gigabit
	task automatic t_link;
		ppc_speed_t sp[4] = '{PPC_SPEED_10, PPC_SPEED_100, PPC_SPEED_RSVD, PPC_SPEED_1000};
		logic [2:0] exp3[4] = '{3'h4, 3'h6, 3'h0, 3'h1};
		wrc(`PPC_ADDR_CFG, 32'h4000, 4'hF, 2'h0);
		for (int i = 0; i < 4; i++)
		begin
			spd <= sp[i];
			repeat (2) @(posedge aclk);
			chk({li, lm, ab}, exp3[i]);
		end
		line_up <= 1'h1;
		repeat (2) @(posedge aclk);
		chk({li, lm, ab}, 3'h5);
		wrc(`PPC_ADDR_CFG, 32'h0, 4'hF, 2'h0);
		spd <= PPC_SPEED_10;
		line_up <= 1'h0;
		repeat (2) @(posedge aclk);
		chk({li, lm, ab}, 3'h0);
	endtask
	// Soft reset with both values of the memory bit
	task automatic t_soft;
		for (int e = 0; e < 2; e++)
		begin
			eeprom <= e[0];
			wrc(`PPC_ADDR_CFG, 32'h3DB2, 4'hF, 2'h0);
			wrc(`PPC_ADDR_CTRL, 32'h1, 4'h1, 2'h0);
			rdc(`PPC_ADDR_CFG, 32'h120 | (e << 7), 2'h0);
		end
	endtask
	task automatic t_unmapped;
		rdc(12'h800, 32'h0, 2'h3);
		wrc(12'h800, 32'h2000, 4'hF, 2'h3);
		rdc(`PPC_ADDR_CFG, 32'h1A0, 2'h0);
	endtask
	// Mid-run hardware reset with the memory bit high: downgrade stays zero
	task automatic t_hw_reset;
		wrc(`PPC_ADDR_CFG, 32'h3DB2, 4'hF, 2'h0);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rdc(`PPC_ADDR_CFG, 32'h120, 2'h0);
		chk(cfg_o, 9'h014);
		chk({li, lm, ab}, 3'h0);
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_fields;
		t_rsvd;
		t_link;
		t_soft;
		t_unmapped;
		t_hw_reset;
		give_verdict;
	end
	// Watchdog well beyond the roughly 150 cycles the run needs
	initial
	begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		give_verdict;
	end
endmodule // phy_port_config_register_bench
`default_nettype wire
